// ==== pkg/bitops_params.svh ====
// Purpose: offsets, field positions, reset values and cycle counts of the bit/flag op unit
// Assumes: 32-bit apb words, one register per aligned word
// Notes:   definitions only
`ifndef BITOPS_PARAMS_SVH
`define BITOPS_PARAMS_SVH

`define OFS_CMD        8'h00
`define OFS_STATUS     8'h04
`define OFS_STATUS_REGISTER       8'h08
`define OFS_GPR_SEL    8'h0C
`define OFS_GPR_DATA   8'h10
`define OFS_IO_SEL     8'h14
`define OFS_IO_DATA    8'h18
`define OFS_CTRL       8'h1C

`define CMD_OP_LSB     0
`define CMD_REG_LSB    8
`define CMD_BIT_LSB    13
`define CMD_IO_LSB     16

`define CTRL_WAKE_BIT  0
`define CTRL_MODE_LSB  4

`define FLAG_C         0
`define FLAG_Z         1
`define FLAG_N         2
`define FLAG_V         3
`define FLAG_S         4
`define FLAG_H         5
`define FLAG_T         6
`define FLAG_I         7

`define STATUS_REGISTER_RESET     8'h00
`define SMODE_RESET    3'h0

`define CYC_SHORT      1
`define CYC_LONG       2

`endif

// ==== pkg/bitops_pkg.sv ====
// Purpose: types shared by the bit/flag op unit
// Assumes: 6-bit operation codes
// Notes:   dedicated flag ops are 6'h20 + 8*set + flag index
package bitops_pkg;

    typedef enum logic [5:0] {
        nop_op                 = 6'h00,
        pop_op                 = 6'h01,
        push_op                = 6'h02,
        io_bit_set_op          = 6'h03,
        io_bit_clear_op        = 6'h04,
        shift_left_logical_op  = 6'h05,
        shift_right_logical_op = 6'h06,
        rotate_left_carry_op   = 6'h07,
        rotate_right_carry_op  = 6'h08,
        shift_right_arith_op   = 6'h09,
        nibble_swap_op         = 6'h0A,
        flag_set_generic_op    = 6'h0B,
        flag_clear_generic_op  = 6'h0C,
        bit_to_transfer_op     = 6'h0D,
        transfer_to_bit_op     = 6'h0E,
        sleep_op               = 6'h0F,
        watchdog_restart_op    = 6'h10,
        break_op               = 6'h11,
        carry_clear_op         = 6'h20, zero_clear_op     = 6'h21,
        negative_clear_op      = 6'h22, overflow_clear_op = 6'h23,
        sign_clear_op          = 6'h24, half_carry_clear_op = 6'h25,
        transfer_clear_op      = 6'h26, int_clear_op      = 6'h27,
        carry_set_op           = 6'h28, zero_set_op       = 6'h29,
        negative_set_op        = 6'h2A, overflow_set_op   = 6'h2B,
        sign_set_op            = 6'h2C, half_carry_set_op = 6'h2D,
        transfer_set_op        = 6'h2E, int_set_op        = 6'h2F
    } op_e;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_EXEC = 2'b10
    } exec_state_e;

endpackage : bitops_pkg

// ==== src/shift_unit.sv ====
// Purpose: shift, rotate and nibble swap datapath with z/c/n/v results
// Assumes: purely combinational, one operand byte
// Notes:   s and h are not touched by these ops
`timescale 1ns/1ps
module shift_unit import bitops_pkg::*; (
    input  wire op_e        op,
    input  wire logic [7:0] din,
    input  wire logic       cin,
    output logic      [7:0] dout,
    output logic            c_out,
    output logic            z_out,
    output logic            n_out,
    output logic            v_out
);
    always_comb begin
        dout  = din;
        c_out = cin;
        case (op)
            shift_left_logical_op: begin
                dout  = {din[6:0], 1'b0};
                c_out = din[7];
            end
            shift_right_logical_op: begin
                dout  = {1'b0, din[7:1]};
                c_out = din[0];
            end
            rotate_left_carry_op: begin
                dout  = {din[6:0], cin};
                c_out = din[7];
            end
            rotate_right_carry_op: begin
                dout  = {cin, din[7:1]};
                c_out = din[0];
            end
            shift_right_arith_op: begin
                dout  = {din[7], din[7:1]};
                c_out = din[0];
            end
            nibble_swap_op: begin
                dout  = {din[3:0], din[7:4]};
            end
            default: begin
                dout  = din;
                c_out = cin;
            end
        endcase
        z_out = (dout == 8'h00);
        n_out = dout[7];
        v_out = dout[7] ^ c_out;
    end
endmodule : shift_unit

// ==== src/flag_unit.sv ====
// Purpose: status register update for flag set/clear and bit store ops
// Assumes: combinational; only the named bit is ever written
// Notes:   ops outside this group pass the status through
`timescale 1ns/1ps
`include "bitops_params.svh"
module flag_unit import bitops_pkg::*; (
    input  wire op_e        op,
    input  wire logic [2:0] bsel,
    input  wire logic [7:0] status_register_in,
    input  wire logic       src_bit,
    output logic      [7:0] status_register_out
);
    always_comb begin
        status_register_out = status_register_in;
        if (op[5]) begin
            status_register_out[op[2:0]] = op[3];
        end else begin
            case (op)
                flag_set_generic_op:   status_register_out[bsel] = 1'b1;
                flag_clear_generic_op: status_register_out[bsel] = 1'b0;
                bit_to_transfer_op:    status_register_out[`FLAG_T] = src_bit;
                default:               status_register_out = status_register_in;
            endcase
        end
    end
endmodule : flag_unit

// ==== src/bitops_core.sv ====
// Purpose: executes the bit, flag and control op group on a small register model
// Assumes: apb slave on clk_sys, 10 MHz; ops issued by writing the command word
// Notes:   bus accesses wait while an op runs, so the bus never races the datapath
//
// What this block does
// - pop loads destination register from stack, two cycles, flags unchanged.
// - io bit set forces addressed io bit to one, two cycles, no flags.
// - io bit clear forces addressed io bit to zero, two cycles, no flags.
// - rotate left through carry, updates z c n v, one cycle.
// - rotate right through carry, updates z c n v, one cycle.
// - bit store copies register bit into transfer flag only, one cycle.
// - bit load copies transfer flag into register bit, no flags, one cycle.
// - set sign forces s to one, one cycle, nothing else.
// - set overflow forces v to one, one cycle, nothing else.
// - clear overflow forces v to zero, one cycle, nothing else.
// - set half carry forces h to one, one cycle, nothing else.
// - clear half carry forces h to zero, one cycle, nothing else.
// - sleep takes one cycle, no flags, enters selected low-power mode.
// - watchdog restart takes one cycle, no flags, restarts watchdog count.
// - break acts only with debug support enabled, no flags.
//
// Chosen here: the APB slave port and the address map.
`timescale 1ns/1ps
`include "bitops_params.svh"
module bitops_core import bitops_pkg::*; (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        debug_en,
    output logic             sleep_active,
    output logic      [2:0]  sleep_mode,
    output logic             wdt_restart,
    output logic             debug_halt
);

    typedef struct packed {
        exec_state_e       st;
        op_e               op;
        logic [4:0]        rd;
        logic [2:0]        bsel;
        logic [4:0]        io;
        logic [1:0]        cnt;
        logic [7:0]        status_register;
        logic [31:0][7:0]  gpr;
        logic [31:0][7:0]  ioreg;
        logic [15:0][7:0]  stack;
        logic [3:0]        sp;
        logic [4:0]        gsel;
        logic [4:0]        isel;
        logic              pready;
        logic              pslverr;
        logic [31:0]       prdata;
        logic              sleep;
        logic [2:0]        smode;
        logic              wdt;
        logic              halt;
        logic [1:0]        dbg_sync;
    } core_s;

    core_s r_reg;
    core_s r_next;

    logic [7:0] sh_dout;
    logic       sh_c;
    logic       sh_z;
    logic       sh_n;
    logic       sh_v;
    logic [7:0] fl_status_register;

    // long ops need the read-modify-write or stack access slot
    function automatic logic is_long(input op_e op);
        return (op == pop_op) || (op == push_op) ||
               (op == io_bit_set_op) || (op == io_bit_clear_op);
    endfunction : is_long

    function automatic logic is_shift(input op_e op);
        return (op == shift_left_logical_op) || (op == shift_right_logical_op) ||
               (op == rotate_left_carry_op) || (op == rotate_right_carry_op) ||
               (op == shift_right_arith_op);
    endfunction : is_shift

    shift_unit u_shift (
        .op    (r_reg.op),
        .din   (r_reg.gpr[r_reg.rd]),
        .cin   (r_reg.status_register[`FLAG_C]),
        .dout  (sh_dout),
        .c_out (sh_c),
        .z_out (sh_z),
        .n_out (sh_n),
        .v_out (sh_v)
    );

    flag_unit u_flag (
        .op       (r_reg.op),
        .bsel     (r_reg.bsel),
        .status_register_in  (r_reg.status_register),
        .src_bit  (r_reg.gpr[r_reg.rd][r_reg.bsel]),
        .status_register_out (fl_status_register)
    );

    always_comb begin
        r_next          = r_reg;
        r_next.pready   = 1'b0;
        r_next.pslverr  = 1'b0;
        r_next.wdt      = 1'b0;
        r_next.dbg_sync = {r_reg.dbg_sync[0], debug_en};

        case (r_reg.st)
            ST_IDLE: begin
                // one wait state; accesses hold off until the datapath is idle
                if (psel && penable && !r_reg.pready) begin
                    r_next.pready = 1'b1;
                    r_next.prdata = 32'h0000_0000;
                    if (pwrite) begin
                        case (paddr)
                            `OFS_CMD: begin
                                if (r_reg.sleep || r_reg.halt) begin
                                    r_next.pslverr = 1'b1;
                                end else begin
                                    r_next.op   = op_e'(pwdata[`CMD_OP_LSB +: 6]);
                                    r_next.rd   = pwdata[`CMD_REG_LSB +: 5];
                                    r_next.bsel = pwdata[`CMD_BIT_LSB +: 3];
                                    r_next.io   = pwdata[`CMD_IO_LSB +: 5];
                                    r_next.cnt  = 2'h0;
                                    r_next.st   = ST_EXEC;
                                end
                            end
                            `OFS_STATUS_REGISTER:     r_next.status_register = pwdata[7:0];
                            `OFS_GPR_SEL:  r_next.gsel = pwdata[4:0];
                            `OFS_GPR_DATA: r_next.gpr[r_reg.gsel] = pwdata[7:0];
                            `OFS_IO_SEL:   r_next.isel = pwdata[4:0];
                            `OFS_IO_DATA:  r_next.ioreg[r_reg.isel] = pwdata[7:0];
                            `OFS_CTRL: begin
                                r_next.smode = pwdata[`CTRL_MODE_LSB +: 3];
                                if (pwdata[`CTRL_WAKE_BIT]) begin
                                    r_next.sleep = 1'b0;
                                    r_next.halt  = 1'b0;
                                end
                            end
                            `OFS_STATUS: r_next.pslverr = 1'b0;
                            default:     r_next.pslverr = 1'b1;
                        endcase
                    end else begin
                        case (paddr)
                            `OFS_CMD: r_next.prdata = {11'h000, r_reg.io,
                                                       r_reg.bsel, r_reg.rd, 2'h0, r_reg.op};
                            `OFS_STATUS: r_next.prdata = {20'h00000, r_reg.sp,
                                                          1'b0, r_reg.smode,
                                                          2'h0, r_reg.halt, r_reg.sleep};
                            `OFS_STATUS_REGISTER:     r_next.prdata = {24'h000000, r_reg.status_register};
                            `OFS_GPR_SEL:  r_next.prdata = {27'h0000000, r_reg.gsel};
                            `OFS_GPR_DATA: r_next.prdata = {24'h000000, r_reg.gpr[r_reg.gsel]};
                            `OFS_IO_SEL:   r_next.prdata = {27'h0000000, r_reg.isel};
                            `OFS_IO_DATA:  r_next.prdata = {24'h000000, r_reg.ioreg[r_reg.isel]};
                            `OFS_CTRL:     r_next.prdata = {25'h0000000, r_reg.smode, 4'h0};
                            default:       r_next.pslverr = 1'b1;
                        endcase
                    end
                end
            end
            ST_EXEC: begin
                if (is_long(r_reg.op) && (r_reg.cnt != 2'(`CYC_LONG - 1))) begin
                    r_next.cnt = r_reg.cnt + 2'h1;
                end else begin
                    r_next.st = ST_IDLE;
                    if (is_shift(r_reg.op)) begin
                        r_next.gpr[r_reg.rd]      = sh_dout;
                        r_next.status_register[`FLAG_C]      = sh_c;
                        r_next.status_register[`FLAG_Z]      = sh_z;
                        r_next.status_register[`FLAG_N]      = sh_n;
                        r_next.status_register[`FLAG_V]      = sh_v;
                    end else if (r_reg.op[5]) begin
                        r_next.status_register = fl_status_register;
                    end else begin
                        case (r_reg.op)
                            pop_op: begin
                                // empty stack wraps; software keeps pushes and pops paired
                                r_next.gpr[r_reg.rd] = r_reg.stack[r_reg.sp - 4'h1];
                                r_next.sp            = r_reg.sp - 4'h1;
                            end
                            push_op: begin
                                r_next.stack[r_reg.sp] = r_reg.gpr[r_reg.rd];
                                r_next.sp              = r_reg.sp + 4'h1;
                            end
                            io_bit_set_op:   r_next.ioreg[r_reg.io][r_reg.bsel] = 1'b1;
                            io_bit_clear_op: r_next.ioreg[r_reg.io][r_reg.bsel] = 1'b0;
                            nibble_swap_op:  r_next.gpr[r_reg.rd] = sh_dout;
                            flag_set_generic_op,
                            flag_clear_generic_op,
                            bit_to_transfer_op: r_next.status_register = fl_status_register;
                            transfer_to_bit_op:
                                r_next.gpr[r_reg.rd][r_reg.bsel] = r_reg.status_register[`FLAG_T];
                            sleep_op:            r_next.sleep = 1'b1;
                            watchdog_restart_op: r_next.wdt = 1'b1;
                            break_op:            r_next.halt = r_reg.dbg_sync[1];
                            default:             r_next.st = ST_IDLE;
                        endcase
                    end
                end
            end
            default: begin
                r_next.st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            r_reg       <= '0;
            r_reg.st    <= ST_IDLE;
            r_reg.status_register  <= `STATUS_REGISTER_RESET;
            r_reg.smode <= `SMODE_RESET;
        end else begin
            r_reg <= r_next;
        end
    end

    assign prdata       = r_reg.prdata;
    assign pready       = r_reg.pready;
    assign pslverr      = r_reg.pslverr;
    assign sleep_active = r_reg.sleep;
    assign sleep_mode   = r_reg.smode;
    assign wdt_restart  = r_reg.wdt;
    assign debug_halt   = r_reg.halt;

endmodule : bitops_core

// ==== verification/bitops_core_properties.sv ====
// Purpose: port-level properties of bitops_core
// Assumes: op effects land one to three cycles after the take edge
// Notes:   debug_en must be steady for three cycles, it is synchronised
`timescale 1ns/1ps
`include "bitops_params.svh"
module bitops_core_properties import bitops_pkg::*; (
    input wire logic        clk_sys,
    input wire logic        rst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        debug_en,
    input wire logic        sleep_active,
    input wire logic [2:0]  sleep_mode,
    input wire logic        wdt_restart,
    input wire logic        debug_halt
);
    logic cmd_acc;
    logic op_ok;
    logic ctrl_acc;
    assign cmd_acc  = psel && penable && pready && pwrite && paddr == `OFS_CMD;
    assign op_ok    = cmd_acc && !pslverr;
    assign ctrl_acc = psel && penable && pready && pwrite && paddr == `OFS_CTRL;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    property p_wdt_pulse; wdt_restart |=> !wdt_restart; endproperty
    a_wdt_pulse: assert property (p_wdt_pulse)
        else $error("restart pulse longer than one cycle");
    property p_wdt_cause; op_ok && pwdata[5:0] == watchdog_restart_op |-> ##[1:3] wdt_restart;
    endproperty
    a_wdt_cause: assert property (p_wdt_cause)
        else $error("restart op gave no pulse");
    property p_sleep_enter; op_ok && pwdata[5:0] == sleep_op |-> ##[1:2] sleep_active; endproperty
    a_sleep_enter: assert property (p_sleep_enter)
        else $error("sleep op did not enter sleep");
    property p_sleep_mode; ctrl_acc |-> ##2 sleep_mode == $past(pwdata[6:4], 2); endproperty
    a_sleep_mode: assert property (p_sleep_mode)
        else $error("sleep mode pins differ from control write");
    // the wake lands at the take edge, one edge before pready is seen
    property p_sleep_hold; sleep_active |=> sleep_active || (ctrl_acc && pwdata[0]);
    endproperty
    a_sleep_hold: assert property (p_sleep_hold)
        else $error("sleep left without wake");
    property p_refuse; cmd_acc && (sleep_active || debug_halt) |-> pslverr; endproperty
    a_refuse: assert property (p_refuse)
        else $error("command taken while asleep or halted");
    property p_wake; ctrl_acc && pwdata[0] |-> ##[1:2] !sleep_active && !debug_halt; endproperty
    a_wake: assert property (p_wake)
        else $error("wake did not clear sleep and halt");
    property p_brk_dbg;
        op_ok && pwdata[5:0] == break_op && debug_en && $past(debug_en, 3) |-> ##[1:3] debug_halt;
    endproperty
    a_brk_dbg: assert property (p_brk_dbg)
        else $error("break with debug support did not halt");
    property p_brk_nodbg;
        op_ok && pwdata[5:0] == break_op && !debug_en && !$past(debug_en, 3)
            |-> ##1 !debug_halt [*3];
    endproperty
    a_brk_nodbg: assert property (p_brk_nodbg)
        else $error("break without debug support halted");
    c_wdt: cover property (wdt_restart);
    c_halt: cover property (debug_halt);
    c_refuse: cover property (cmd_acc && pslverr);
endmodule : bitops_core_properties

// ==== verification/testbench.sv ====
// Purpose: directed apb test of the bit/flag op unit
// Assumes: one wait state when idle, longer while an op runs
// Notes:   bus answers sampled at the rising edge, before that edge's updates land
`timescale 1ns/1ps
`include "bitops_params.svh"
module testbench import bitops_pkg::*;;
    logic        clk_sys, rst_n, psel, penable, pwrite, debug_en, err;
    logic [7:0]  paddr, sr, v;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, sleep_active, wdt_restart, debug_halt;
    logic [2:0]  sleep_mode;
    logic [8:0]  m;
    int          error_cnt, checks;
    int          wdt_cnt = 0;
    logic [7:0]  vals [3] = '{8'h96, 8'h01, 8'h80};
    op_e         sh_ops [7] = '{shift_left_logical_op, shift_right_logical_op,
        rotate_left_carry_op, rotate_right_carry_op, shift_right_arith_op, nibble_swap_op, nop_op};
    bitops_core bitops_core_i (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .debug_en(debug_en), .sleep_active(sleep_active),
        .sleep_mode(sleep_mode), .wdt_restart(wdt_restart), .debug_halt(debug_halt));
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    always @(negedge clk_sys) wdt_cnt += (wdt_restart === 1'b1);
    task give_verdict;
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : give_verdict
    task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    // pready is a register: read just after the edge it still shows what the previous edge loaded
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
            if (n > 200) begin
                error_cnt++;
                give_verdict();
            end
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task cmd(input op_e o, input logic [4:0] r, input logic [2:0] b, input logic [4:0] io);
        apb(1'b1, `OFS_CMD, {11'h0, io, b, r, 2'b00, o});
    endtask : cmd
    task setg(input logic [4:0] r, input logic [7:0] d);
        apb(1'b1, `OFS_GPR_SEL, {27'h0, r});
        apb(1'b1, `OFS_GPR_DATA, {24'h0, d});
    endtask : setg
    task getg(input logic [4:0] r);
        apb(1'b1, `OFS_GPR_SEL, {27'h0, r});
        apb(1'b0, `OFS_GPR_DATA, 32'h0);
    endtask : getg
    function automatic logic [8:0] shift_model(input op_e o, input logic [7:0] d, input logic c);
        case (o)
            shift_left_logical_op:  return {d[7], d[6:0], 1'b0};
            shift_right_logical_op: return {d[0], 1'b0, d[7:1]};
            rotate_left_carry_op:   return {d[7], d[6:0], c};
            rotate_right_carry_op:  return {d[0], c, d[7:1]};
            shift_right_arith_op:   return {d[0], d[7], d[7:1]};
            nibble_swap_op:         return {c, d[3:0], d[7:4]};
            default:                return {c, d};
        endcase
    endfunction : shift_model
    initial begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        debug_en = 1'b0;
        error_cnt = 0;
        checks = 0;
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        apb(1'b0, `OFS_STATUS_REGISTER, 32'h0);
        chk("flags", rd, {24'h0, `STATUS_REGISTER_RESET});
        apb(1'b0, `OFS_STATUS, 32'h0);
        chk("status", rd, 32'h0);
        $display("test reset done");
        // shifts, rotates, nibble swap and nop with carry in low and high, zero results at the edges
        foreach (sh_ops[i]) begin
            for (int k = 0; k < 6; k++) begin
                v = vals[k % 3];
                sr = (k < 3) ? 8'h30 : 8'h31;
                apb(1'b1, `OFS_STATUS_REGISTER, {24'h0, sr});
                setg(5'd7, v);
                cmd(sh_ops[i], 5'd7, 3'd0, 5'd0);
                m = shift_model(sh_ops[i], v, sr[`FLAG_C]);
                getg(5'd7);
                chk("shift result", rd, {24'h0, m[7:0]});
                if (sh_ops[i] != nibble_swap_op && sh_ops[i] != nop_op) begin
                    sr[`FLAG_C] = m[8];
                    sr[`FLAG_Z] = (m[7:0] == 8'h00);
                    sr[`FLAG_N] = m[7];
                    sr[`FLAG_V] = m[7] ^ m[8];
                end
                apb(1'b0, `OFS_STATUS_REGISTER, 32'h0);
                chk("shift flags", rd, {24'h0, sr});
            end
        end
        $display("test shifts done");
        for (int f = 0; f < 16; f++) begin
            sr = 8'h5A ^ 8'(f * 37);
            v = f[3] ? (sr | (8'h01 << f[2:0])) : (sr & ~(8'h01 << f[2:0]));
            apb(1'b1, `OFS_STATUS_REGISTER, {24'h0, sr});
            cmd(op_e'({2'b10, f[3:0]}), 5'd0, 3'd0, 5'd0);
            apb(1'b0, `OFS_STATUS_REGISTER, 32'h0);
            chk("flag op", rd, {24'h0, v});
            apb(1'b1, `OFS_STATUS_REGISTER, {24'h0, sr});
            cmd(f[3] ? flag_set_generic_op : flag_clear_generic_op, 5'd0, f[2:0], 5'd0);
            apb(1'b0, `OFS_STATUS_REGISTER, 32'h0);
            chk("generic flag op", rd, {24'h0, v});
        end
        $display("test flags done");
        apb(1'b1, `OFS_STATUS_REGISTER, 32'h40);
        setg(5'd3, 8'hA5);
        cmd(bit_to_transfer_op, 5'd3, 3'd1, 5'd0);
        apb(1'b0, `OFS_STATUS_REGISTER, 32'h0);
        chk("bit store low", rd, 32'h00);
        cmd(bit_to_transfer_op, 5'd3, 3'd2, 5'd0);
        setg(5'd4, 8'h00);
        cmd(transfer_to_bit_op, 5'd4, 3'd7, 5'd0);
        getg(5'd4);
        chk("bit load high", rd, 32'h80);
        apb(1'b1, `OFS_STATUS_REGISTER, 32'hBF);
        setg(5'd4, 8'hFF);
        cmd(transfer_to_bit_op, 5'd4, 3'd0, 5'd0);
        getg(5'd4);
        chk("bit load low", rd, 32'hFE);
        apb(1'b0, `OFS_STATUS_REGISTER, 32'h0);
        chk("bit load flags", rd, 32'hBF);
        $display("test bit transfer done");
        // two long ops back to back, the first has finished before the second is taken
        apb(1'b1, `OFS_IO_SEL, 32'h5);
        apb(1'b1, `OFS_IO_DATA, 32'h0F);
        cmd(io_bit_set_op, 5'd0, 3'd7, 5'd5);
        cmd(io_bit_clear_op, 5'd0, 3'd0, 5'd5);
        apb(1'b0, `OFS_IO_DATA, 32'h0);
        chk("io bits", rd, 32'h8E);
        setg(5'd1, 8'h3C);
        cmd(push_op, 5'd1, 3'd0, 5'd0);
        cmd(pop_op, 5'd2, 3'd0, 5'd0);
        getg(5'd2);
        chk("pop value", rd, 32'h3C);
        apb(1'b0, `OFS_STATUS_REGISTER, 32'h0);
        chk("io and pop flags", rd, 32'hBF);
        $display("test long ops done");
        cmd(watchdog_restart_op, 5'd0, 3'd0, 5'd0);
        apb(1'b0, `OFS_STATUS_REGISTER, 32'h0);
        chk("restart pulses", wdt_cnt, 32'h1);
        apb(1'b1, `OFS_CTRL, 32'h50);
        cmd(sleep_op, 5'd0, 3'd0, 5'd0);
        apb(1'b0, `OFS_STATUS, 32'h0);
        chk("sleep status", rd, 32'h51);
        chk("sleep pin", {31'h0, sleep_active}, 32'h1);
        @(negedge clk_sys);
        chk("sleep mode pins", {29'h0, sleep_mode}, 32'h5);
        cmd(nop_op, 5'd0, 3'd0, 5'd0);
        chk("refused in sleep", err, 32'h1);
        apb(1'b1, `OFS_CTRL, 32'h51);
        cmd(break_op, 5'd0, 3'd0, 5'd0);
        apb(1'b0, `OFS_STATUS, 32'h0);
        chk("break without debug", rd, 32'h50);
        @(posedge clk_sys);
        debug_en <= 1'b1;
        repeat (4) @(posedge clk_sys);
        cmd(break_op, 5'd0, 3'd0, 5'd0);
        apb(1'b0, `OFS_STATUS, 32'h0);
        chk("break with debug", rd, 32'h52);
        chk("halt pin", {31'h0, debug_halt}, 32'h1);
        cmd(nop_op, 5'd0, 3'd0, 5'd0);
        chk("refused in halt", err, 32'h1);
        apb(1'b1, `OFS_CTRL, 32'h51);
        apb(1'b0, `OFS_STATUS_REGISTER, 32'h0);
        chk("control op flags", rd, 32'hBF);
        $display("test control ops done");
        apb(1'b1, 8'h20, 32'hFF);
        chk("unmapped write error", err, 32'h1);
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped read data", rd, 32'h0);
        chk("unmapped read error", err, 32'h1);
        apb(1'b1, `OFS_STATUS, 32'hFF);
        chk("status write error", err, 32'h0);
        $display("test map done");
        give_verdict();
    end
endmodule : testbench
bind bitops_core bitops_core_properties bitops_core_properties_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .debug_en(debug_en), .sleep_active(sleep_active), .sleep_mode(sleep_mode),
    .wdt_restart(wdt_restart), .debug_halt(debug_halt));
